// file: src/rtdvp_defs.vh
// constants for the rtd voting protection block
`ifndef RTDVP_DEFS_VH
`define RTDVP_DEFS_VH
`define RTDVP_MODS 3
`define RTDVP_CPM 8
`define RTDVP_TW 16
`define RTDVP_CODE_NOSENS 16'h2710
`define RTDVP_CODE_OPEN 16'hdcd8
`define RTDVP_CODE_SHORT 16'he0c0
`define RTDVP_CODE_NODATA 16'he4a8
`define RTDVP_FLT_OK 2'h0
`define RTDVP_FLT_OPEN 2'h1
`define RTDVP_FLT_SHORT 2'h2
`define RTDVP_FLT_NODATA 2'h3
`define RTDVP_GRP_STATOR 2'h0
`define RTDVP_FUNC_VOTE_BIT 2
`define RTDVP_SET_MIN 16'h0fa0
`define RTDVP_SET_MAX 16'h4e20
`define RTDVP_COMP_SPAN 16'h03e8
`define RTDVP_CAP_FULL 16'h2710
`define RTDVP_CAP_LIMIT 16'h2328
`endif

// file: src/rtdvp_core.v
// rtd voting protection: thresholds, voting, failure codes, hot-motor compensation
`timescale 1ns/1ns
`include "rtdvp_defs.vh"
module rtdvp_core #(
  parameter MODS = `RTDVP_MODS,
  parameter CPM = `RTDVP_CPM,
  parameter TW = `RTDVP_TW
) (
  // clock and reset
  input wire core_clk_i,
  input wire nrst_i,
  // configuration
  input wire [1:0] module_count_i,
  input wire [MODS*CPM-1:0] chan_type_i,
  input wire [MODS*CPM*3-1:0] chan_func_i,
  input wire [MODS*CPM*TW-1:0] chan_trip_lvl_i,
  input wire [MODS*CPM*TW-1:0] chan_alarm_lvl_i,
  input wire [2:0] temp_trip_action_i,
  input wire [2:0] temp_alarm_action_i,
  input wire [2:0] fail_trip_action_i,
  input wire [2:0] fail_alarm_action_i,
  // sensor module data
  input wire [MODS*CPM*TW-1:0] chan_temp_i,
  input wire [MODS*CPM*2-1:0] chan_fault_i,
  // resets
  input wire [MODS*CPM-1:0] chan_reset_i,
  input wire emergency_thermal_reset_i,
  // compensation
  input wire hot_motor_comp_en_i,
  input wire [TW-1:0] comp_low_temp_i,
  input wire [TW-1:0] comp_high_temp_i,
  input wire [TW-1:0] model_temp_i,
  input wire [TW-1:0] model_capacity_i,
  // status
  output reg [MODS*CPM-1:0] chan_trip_o,
  output reg [MODS*CPM-1:0] chan_alarm_o,
  output reg [MODS*CPM-1:0] chan_fail_o,
  output reg [MODS*CPM*TW-1:0] chan_value_o,
  output reg [2:0] trip_out_o,
  output reg [2:0] alarm_out_o,
  output reg start_permit_o,
  output reg model_reinit_o,
  output reg [TW-1:0] used_thermal_capacity_o
);
  localparam NCH = MODS * CPM;

  // settings outside the legal span are pulled to its edges
  function [TW-1:0] rtdvp_clamp;
    input [TW-1:0] v;
    begin
      if ($signed(v) < $signed(`RTDVP_SET_MIN)) begin
        rtdvp_clamp = `RTDVP_SET_MIN;
      end else if ($signed(v) > $signed(`RTDVP_SET_MAX)) begin
        rtdvp_clamp = `RTDVP_SET_MAX;
      end else begin
        rtdvp_clamp = v;
      end
    end
  endfunction

  // a reading counts only when strictly above its clamped set point
  function rtdvp_above;
    input [TW-1:0] t;
    input [TW-1:0] lvl;
    begin
      rtdvp_above = $signed(t) > $signed(rtdvp_clamp(lvl));
    end
  endfunction

  // group field of a channel's function code
  function [1:0] rtdvp_group;
    input [2:0] fn;
    begin
      rtdvp_group = fn[1:0];
    end
  endfunction

  // voting flag of a channel's function code
  function rtdvp_votes;
    input [2:0] fn;
    begin
      rtdvp_votes = fn[`RTDVP_FUNC_VOTE_BIT];
    end
  endfunction

  // error code shown in place of a reading
  function [TW-1:0] rtdvp_code;
    input [1:0] f;
    begin
      if (f == `RTDVP_FLT_OPEN) begin
        rtdvp_code = `RTDVP_CODE_OPEN;
      end else if (f == `RTDVP_FLT_SHORT) begin
        rtdvp_code = `RTDVP_CODE_SHORT;
      end else begin
        rtdvp_code = `RTDVP_CODE_NODATA;
      end
    end
  endfunction

  // release is synchronised so no flop leaves reset a cycle before its neighbours
  reg rst_meta;
  reg rst_n;
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  wire therm_rst = emergency_thermal_reset_i;
  wire [NCH-1:0] active;
  wire [NCH-1:0] failed;
  wire [NCH-1:0] hot;
  wire [NCH-1:0] warm;
  wire [NCH*TW-1:0] next_value;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : ch
      wire [TW-1:0] t = chan_temp_i[g*TW +: TW];
      wire [1:0] f = chan_fault_i[g*2 +: 2];
      // modules beyond the configured count give no data
      wire fitted = (g / CPM) < module_count_i;
      wire bad = chan_type_i[g] & (~fitted | (f != `RTDVP_FLT_OK));
      assign failed[g] = bad;
      assign active[g] = chan_type_i[g] & ~bad;
      assign hot[g] = active[g] & rtdvp_above(t, chan_trip_lvl_i[g*TW +: TW]);
      assign warm[g] = active[g] & rtdvp_above(t, chan_alarm_lvl_i[g*TW +: TW]);
      // a configured channel on an unfitted module reads as a module error, whatever its link shows
      assign next_value[g*TW +: TW] = !chan_type_i[g] ? `RTDVP_CODE_NOSENS :
        !fitted ? rtdvp_code(`RTDVP_FLT_NODATA) :
        (f != `RTDVP_FLT_OK) ? rtdvp_code(f) : t;
    end
  endgenerate

  // voting: counts limited to the same module and the same whole function code, voting flag included
  integer c;
  integer k;
  integer j;
  integer n_act;
  integer n_hot;
  reg [NCH-1:0] trip_set;
  always @* begin
    trip_set = {NCH{1'b0}};
    n_act = 0;
    n_hot = 0;
    j = 0;
    for (c = 0; c < NCH; c = c + 1) begin
      n_act = 0;
      n_hot = 0;
      for (k = 0; k < CPM; k = k + 1) begin
        j = (c / CPM) * CPM + k;
        if (chan_func_i[j*3 +: 3] == chan_func_i[c*3 +: 3]) begin
          if (active[j]) begin
            n_act = n_act + 1;
          end
          // a latched partner keeps the vote so later trips are not locked out
          if (active[j] && (hot[j] || chan_trip_o[j])) begin
            n_hot = n_hot + 1;
          end
        end
      end
      if (!rtdvp_votes(chan_func_i[c*3 +: 3])) begin
        trip_set[c] = hot[c];
      end else if (n_act <= 1) begin
        trip_set[c] = hot[c];
      end else begin
        trip_set[c] = hot[c] && (n_hot >= 2);
      end
    end
  end

  // hottest healthy stator channel
  integer s;
  reg [TW-1:0] stator_max;
  reg stator_any;
  always @* begin
    stator_max = {TW{1'b0}};
    stator_any = 1'b0;
    for (s = 0; s < NCH; s = s + 1) begin
      // failed stator sensors are skipped so a broken lead cannot bias the model
      if (active[s] && (rtdvp_group(chan_func_i[s*3 +: 3]) == `RTDVP_GRP_STATOR)) begin
        if (!stator_any || $signed(chan_temp_i[s*TW +: TW]) > $signed(stator_max)) begin
          stator_max = chan_temp_i[s*TW +: TW];
        end
        stator_any = 1'b1;
      end
    end
  end

  wire [TW-1:0] lo = rtdvp_clamp(comp_low_temp_i);
  wire [TW-1:0] hi = rtdvp_clamp(comp_high_temp_i);
  wire [TW:0] lo_span = {1'b0, lo} + {1'b0, `RTDVP_COMP_SPAN};
  wire comp_ok = hot_motor_comp_en_i && ({1'b0, hi} >= lo_span);
  wire [TW-1:0] span = hi - lo;
  wire [TW-1:0] rise = stator_max - lo;
  // combinational divide is slow; the result is compared and muxed before the capacity register
  wire [2*TW-1:0] prod = rise * `RTDVP_CAP_FULL;
  wire [2*TW-1:0] quot = (span == {TW{1'b0}}) ? {2*TW{1'b0}} : prod / {{TW{1'b0}}, span};
  reg [TW-1:0] bias;
  always @* begin
    if (!stator_any || ($signed(stator_max) <= $signed(lo))) begin
      bias = {TW{1'b0}};
    end else if ($signed(stator_max) >= $signed(hi)) begin
      bias = `RTDVP_CAP_FULL;
    end else begin
      bias = quot[TW-1:0];
    end
    if (bias > `RTDVP_CAP_LIMIT) begin
      bias = `RTDVP_CAP_LIMIT;
    end
  end
  wire comp_use = comp_ok && stator_any &&
    ($signed(stator_max) > $signed(model_temp_i)) && (bias > model_capacity_i);

  // while the emergency reset is held no trip can be set and old ones clear
  wire [NCH-1:0] next_trip = therm_rst ? {NCH{1'b0}} :
    (trip_set | (chan_trip_o & ~chan_reset_i));
  // alarms go quiet as well, since all temperature protection is off then
  wire [NCH-1:0] next_alarm = therm_rst ? {NCH{1'b0}} : warm;
  wire any_fail = |failed;
  // failure actions are levels: they drop as soon as the sensor recovers
  wire [2:0] next_trip_out = ({3{|next_trip}} & temp_trip_action_i) |
    ({3{any_fail}} & fail_trip_action_i);
  wire [2:0] next_alarm_out = ({3{|next_alarm}} & temp_alarm_action_i) |
    ({3{any_fail}} & fail_alarm_action_i);
  wire [TW-1:0] next_capacity = comp_use ? bias : model_capacity_i;

  // per-channel trip latches and live alarms
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      chan_trip_o <= {NCH{1'b0}};
      chan_alarm_o <= {NCH{1'b0}};
    end else begin
      chan_trip_o <= next_trip;
      chan_alarm_o <= next_alarm;
    end
  end

  // failure flags and network-readable values
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      chan_fail_o <= {NCH{1'b0}};
      chan_value_o <= {NCH*TW{1'b0}};
    end else begin
      chan_fail_o <= failed;
      chan_value_o <= next_value;
    end
  end

  // shared trip and alarm outputs
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      trip_out_o <= 3'h0;
      alarm_out_o <= 3'h0;
    end else begin
      trip_out_o <= next_trip_out;
      alarm_out_o <= next_alarm_out;
    end
  end

  // start permission and thermal model reinit
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      start_permit_o <= 1'b0;
      model_reinit_o <= 1'b0;
    end else begin
      start_permit_o <= ~|next_trip;
      model_reinit_o <= therm_rst;
    end
  end

  // used capacity, biased only while compensation applies
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      used_thermal_capacity_o <= {TW{1'b0}};
    end else begin
      used_thermal_capacity_o <= next_capacity;
    end
  end
endmodule // rtdvp_core

// file: tb/rtdvp_sensor_model.sv
// sensor module model: per-channel readings and fault codes
`timescale 1ns/1ns
module rtdvp_sensor_model #(parameter N = 24) (
  // stimulus
  input wire [15:0] base_i,
  input wire [15:0] hot_i,
  input wire [N-1:0] hot_mask_i,
  input wire [N*2-1:0] fault_i,
  // module link
  output reg [N*16-1:0] temp_o,
  output reg [N*2-1:0] fault_o
);
  integer c;
  always @* begin
    for (c = 0; c < N; c = c + 1) begin
      // a failed sensor has no valid reading, so its line shows garbage
      temp_o[c*16+:16] = (fault_i[c*2+:2] != 2'h0) ? ~hot_i :
        (hot_mask_i[c] ? hot_i : base_i);
      fault_o[c*2+:2] = fault_i[c*2+:2];
    end
  end
endmodule // rtdvp_sensor_model

// file: tb/rtdvp_checker.sv
// assertions on the rtd voting protection core ports
`timescale 1ns/1ns
module rtdvp_checker #(parameter MODS = 3, parameter CPM = 8, parameter TW = 16) (
  input wire core_clk_i,
  input wire nrst_i,
  input wire [MODS*CPM-1:0] chan_reset_i,
  input wire emergency_thermal_reset_i,
  input wire hot_motor_comp_en_i,
  input wire [TW-1:0] comp_low_temp_i,
  input wire [TW-1:0] comp_high_temp_i,
  input wire [TW-1:0] model_capacity_i,
  input wire [MODS*CPM-1:0] chan_trip_o,
  input wire [MODS*CPM-1:0] chan_alarm_o,
  input wire [MODS*CPM-1:0] chan_fail_o,
  input wire start_permit_o,
  input wire model_reinit_o,
  input wire [TW-1:0] used_thermal_capacity_o
);
  // outputs carry computed values only from the third edge after release
  reg [1:0] up;
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i || up != 2'h3);
  sequence held_s;
    chan_trip_o[0] && !chan_reset_i[0] && !emergency_thermal_reset_i;
  endsequence
  chk_emerg_clears: assert property (emergency_thermal_reset_i
    |=> chan_trip_o == 0 && chan_alarm_o == 0)
    else $error("trip survived emergency reset");
  chk_reinit_copy: assert property (emergency_thermal_reset_i |=> model_reinit_o)
    else $error("reinit missing");
  chk_permit_trip: assert property (chan_trip_o != 0 |-> !start_permit_o)
    else $error("start permitted with trip");
  chk_trip_held: assert property (held_s |=> chan_trip_o[0])
    else $error("trip dropped without reset");
  chk_fail_quiet: assert property (((chan_fail_o & chan_alarm_o)
    | (chan_fail_o & chan_trip_o & ~$past(chan_trip_o))) == 0)
    else $error("failed channel tripped");
  chk_cap_limit: assert property (used_thermal_capacity_o <= 16'h2328
    || used_thermal_capacity_o == $past(model_capacity_i))
    else $error("capacity above limit");
  chk_comp_off: assert property (!hot_motor_comp_en_i
    |=> used_thermal_capacity_o == $past(model_capacity_i))
    else $error("comp active while disabled");
  chk_comp_span: assert property (int'($signed(comp_high_temp_i))
    < int'($signed(comp_low_temp_i)) + 1000
    |=> used_thermal_capacity_o == $past(model_capacity_i))
    else $error("comp active with narrow span");
endmodule // rtdvp_checker
bind rtdvp_core rtdvp_checker #(.MODS(MODS), .CPM(CPM), .TW(TW)) rtdvp_checker_inst (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .chan_reset_i(chan_reset_i),
  .emergency_thermal_reset_i(emergency_thermal_reset_i), .hot_motor_comp_en_i(hot_motor_comp_en_i),
  .comp_low_temp_i(comp_low_temp_i), .comp_high_temp_i(comp_high_temp_i),
  .model_capacity_i(model_capacity_i), .chan_trip_o(chan_trip_o), .chan_alarm_o(chan_alarm_o),
  .chan_fail_o(chan_fail_o), .start_permit_o(start_permit_o), .model_reinit_o(model_reinit_o),
  .used_thermal_capacity_o(used_thermal_capacity_o));

// file: tb/rtdvp_core_test.sv
// self-checking bench for the rtd voting protection core
`timescale 1ns/1ns
module rtdvp_core_test;
  reg clk = 0, nrst = 0, emr = 0, en = 0;
  reg [1:0] mc = 2'h3;
  reg [23:0] ty = 24'hffffff, hm = 0, rst = 0;
  reg [71:0] fn = {24{3'h1}};
  reg [47:0] flt = 0;
  reg [15:0] hot = 16'h1f40, lo = 16'h1388, hi = 16'h3a98, mt = 16'h0fa0, mcap = 0;
  wire [383:0] tmp, val;
  wire [47:0] fo;
  wire [23:0] trip, alarm, fail;
  wire [2:0] tout, aout;
  wire permit, reinit;
  wire [15:0] used;
  integer fail_count = 0, tests_run = 0, k, t, m, r;
  initial forever #10 clk = ~clk;
  rtdvp_sensor_model rtdvp_sensor_model_inst (.base_i(16'h0bb8), .hot_i(hot), .hot_mask_i(hm),
    .fault_i(flt), .temp_o(tmp), .fault_o(fo));
  rtdvp_core rtdvp_core_inst (.core_clk_i(clk), .nrst_i(nrst), .module_count_i(mc),
    .chan_type_i(ty), .chan_func_i(fn), .chan_trip_lvl_i({24{16'h1770}}),
    .chan_alarm_lvl_i({24{16'h1388}}), .temp_trip_action_i(3'h1), .temp_alarm_action_i(3'h2),
    .fail_trip_action_i(3'h4), .fail_alarm_action_i(3'h4),
    .chan_temp_i(tmp), .chan_fault_i(fo),
    .chan_reset_i(rst), .emergency_thermal_reset_i(emr), .hot_motor_comp_en_i(en),
    .comp_low_temp_i(lo), .comp_high_temp_i(hi), .model_temp_i(mt), .model_capacity_i(mcap),
    .chan_trip_o(trip), .chan_alarm_o(alarm), .chan_fail_o(fail), .chan_value_o(val),
    .trip_out_o(tout), .alarm_out_o(aout), .start_permit_o(permit), .model_reinit_o(reinit),
    .used_thermal_capacity_o(used));
  task step(input integer n);
    begin repeat (n) @(posedge clk); #2; end
  endtask
  task chk(input string n, input [23:0] e, input [23:0] g);
    begin
      tests_run++;
      if (g !== e) begin
        fail_count++;
        $display("mismatch %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  // bias grows linearly over the 50.00 to 150.00 span used here
  function [15:0] cap_exp(input integer t, input integer m);
    integer b;
    begin
      b = (t <= 5000) ? 0 : ((t >= 15000) ? 10000 : t - 5000);
      if (b > 9000) b = 9000;
      cap_exp = (b > m) ? b : m;
    end
  endfunction
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    r = $urandom(32'h5897);
    repeat (8) @(posedge clk);
    #2 nrst = 1;
    step(3);
    hm = 24'h1; step(2);
    chk("trip", 24'h1, trip);
    chk("alarm", 24'h1, alarm);
    chk("trip_out", 24'h1, tout);
    chk("alarm_out", 24'h2, aout);
    chk("permit", 24'h0, permit);
    hm = 0; step(1);
    chk("alarm_live", 24'h0, alarm);
    chk("trip_held", 24'h1, trip);
    rst = 24'h1; step(1); rst = 0;
    chk("trip_reset", 24'h0, trip);
    chk("permit_back", 24'h1, permit);
    $display("plain trip done");
    fn = {24{3'h4}}; hm = 24'h101; step(2);
    chk("vote_one", 24'h0, trip);
    hm = 24'h103; step(1);
    chk("vote_two", 24'h3, trip);
    hm = 24'h107; step(1);
    chk("vote_more", 24'h7, trip);
    chk("vote_alarm", 24'h107, alarm);
    emr = 1; step(2);
    chk("emr_trip", 24'h0, trip);
    chk("emr_alarm", 24'h0, alarm);
    chk("emr_reinit", 24'h1, reinit);
    emr = 0; hm = 0; rst = 24'hffffff; step(1); rst = 0;
    $display("voting done");
    flt = 48'h5554; hm = 24'h1; step(2);
    chk("vote_lone", 24'h1, trip);
    chk("fail", 24'hfe, fail);
    chk("fail_out", 24'h5, tout);
    chk("fail_alarm", 24'h6, aout);
    for (k = 1; k < 4; k++) begin
      flt[3:2] = k; step(1);
      chk("code", {16'he4a8, 16'he0c0, 16'hdcd8} >> (k * 16 - 16) & 24'hffff, val[31:16]);
    end
    ty[2] = 0; mc = 2'h2; step(1);
    chk("no_sensor", 24'h2710, val[47:32]);
    chk("unfitted", 24'he4a8, val[271:256]);
    flt = 0; hm = 0; ty = 24'hffffff; mc = 2'h3; rst = 24'hffffff; step(1); rst = 0;
    $display("failure done");
    fn = {24{3'h0}}; hm = 24'h1; en = 1;
    for (k = 0; k < 24; k++) begin
      t = (k == 0) ? 15000 : ((k == 1) ? 5000 : 4000 + $urandom % 16001);
      m = $urandom % 10000;
      hot = t; mcap = m; step(1);
      chk("capacity", cap_exp(t, m), used);
      chk("value", t, val[15:0]);
    end
    hot = 16'h2710; mcap = 0; hi = 16'h176f; step(1);
    chk("narrow_span", 24'h0, used);
    hi = 16'h3a98; en = 0; step(1);
    chk("comp_off", 24'h0, used);
    $display("compensation done");
    give_verdict;
  end
endmodule // rtdvp_core_test
